// ==== src/adcc_regs.svh ====
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define ADCC_ADDR_MODE 4'h0
`define ADCC_ADDR_CHSEL 4'h1
`define ADCC_ADDR_RESULT 4'h2
`define ADCC_ADDR_STATUS 4'h3

// ****************************************
// field positions
// ****************************************
`define ADCC_MODE_ENABLE_BIT 7
`define ADCC_MODE_SOURCE_BIT 6
`define ADCC_MODE_EDGE_HI_BIT 2
`define ADCC_MODE_EDGE_LO_BIT 1
`define ADCC_STATUS_FLAG_BIT 0
`define ADCC_RESULT_PAD_BITS 6

// ****************************************
// reset values and msb trial code
// ****************************************
`define ADCC_MODE_RST 8'h00
`define ADCC_CHSEL_RST 3'h0
`define ADCC_RESULT_RST 16'h0000
`define ADCC_MSB_TRIAL 10'h200

// ****************************************
// timing
// ****************************************
`define ADCC_CLK_MHZ 100
`define ADCC_SAMPLE_NS 40
`define ADCC_BIT_NS 40
`define ADCC_SAMPLE_CYC ((`ADCC_SAMPLE_NS * `ADCC_CLK_MHZ + 999) / 1000)
`define ADCC_BIT_CYC ((`ADCC_BIT_NS * `ADCC_CLK_MHZ + 999) / 1000)

`endif

// ==== src/adcc_pkg.sv ====
`default_nettype none
package adcc_pkg;
  typedef enum logic [3:0] {
    ADCC_IDLE = 4'b0001,
    ADCC_WAIT = 4'b0010,
    ADCC_SAMPLE = 4'b0100,
    ADCC_CONV = 4'b1000
  } adcc_state_t;
endpackage
`default_nettype wire

// ==== src/adcc_trig_edge.sv ====
`default_nettype none
module adcc_trig_edge (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_pin,
  input wire logic [1:0] i_edge_sel,
  output logic o_hit
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // ****************************************
  // two-flop synchroniser and history
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // (RL17) edge select decode
  assign o_hit = (i_edge_sel[1] && sync2_q && !prev_q) ||
                 (i_edge_sel[0] && !sync2_q && prev_q);
endmodule
`default_nettype wire

// ==== src/adcc_top.sv ====
// Design decisions made here: the address-and-strobe port and the register offsets.
`default_nettype none
`include "adcc_regs.svh"

// Notes on behaviour
// (RL1) results are 10 bits, input chosen from 8 channels
// (RL2) one channel per conversion, latched when conversion starts
// (RL3) hardware mode starts on trigger edge: rising, falling or both
// (RL4) hardware mode stops after one conversion and raises end request
// (RL5) software mode repeats conversions, end request after every one
// (RL6) bits resolved msb first, each by comparator against tap voltage
// (RL7) after lsb, approximation copied into result, marking end of conversion
// (RL8) writing channel select leaves the end flag unchanged
// (RL9) old channel may finish and flag just before a channel rewrite
// (RL10) software clears end flag before restarting a stopped converter
// (RL11) software should discard first result after start, polling end request
// (RL12) mode or channel write may spoil result; software reads first
// (RL13) completion meeting a stop may spoil result; software reads first
// (RL14) sampling takes about a tenth of conversion, bits follow
// (RL15) software avoids shared digital input port during conversion
// (RL16) mode bit 7 enables conversion, bit 6 selects hardware start
// (RL17) edge field: 00 none, 01 falling, 10 rising, 11 both
// (RL18) result is 16 bits, left aligned, low 6 bits zero
// (RL19) software mode channel rewrite aborts and restarts on new channel
// (RL20) end flag set in same cycle result register loads
module adcc_top (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_external_trigger_in,
  input wire logic i_cmp_hi,
  output logic [2:0] o_chan_sel,
  output logic o_sample_en,
  output logic [9:0] o_tap_code,
  output logic o_conv_end_irq
);
  localparam logic [2:0] SAMP_LAST = 3'(`ADCC_SAMPLE_CYC - 1);
  localparam logic [2:0] BIT_LAST = 3'(`ADCC_BIT_CYC - 1);

  adcc_pkg::adcc_state_t state_q;
  adcc_pkg::adcc_state_t state_d;
  logic [7:1] converter_mode_reg_q;
  logic [2:0] channel_select_reg_q;
  logic [2:0] chan_q;
  logic [15:0] conversion_result_reg_q;
  logic [9:0] successive_approx_reg_q;
  logic [3:0] bit_q;
  logic [2:0] cnt_q;
  logic conv_end_flag_q;
  logic irq_q;
  logic sample_q;
  logic [15:0] rdata_q;
  logic wr_mode;
  logic wr_chsel;
  logic wr_status;
  logic restart;
  logic enabled;
  logic hw_start;
  logic trig_hit;
  logic bit_dec;
  logic last_bit;
  logic done_evt;
  logic start_sample;
  logic [2:0] chsel_next;

  // ****************************************
  // bus decode
  // ****************************************
  assign wr_mode = i_wr && (i_addr == `ADCC_ADDR_MODE);
  assign wr_chsel = i_wr && (i_addr == `ADCC_ADDR_CHSEL);
  assign wr_status = i_wr && (i_addr == `ADCC_ADDR_STATUS);
  assign restart = wr_mode || wr_chsel;
  // (RL16) enable and source bits
  assign enabled = converter_mode_reg_q[`ADCC_MODE_ENABLE_BIT];
  assign hw_start = converter_mode_reg_q[`ADCC_MODE_SOURCE_BIT];
  assign chsel_next = wr_chsel ? i_wdata[2:0] : channel_select_reg_q;

  // ****************************************
  // trigger pin
  // ****************************************
  adcc_trig_edge u_trig (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_pin(i_external_trigger_in),
    .i_edge_sel({converter_mode_reg_q[`ADCC_MODE_EDGE_HI_BIT],
                 converter_mode_reg_q[`ADCC_MODE_EDGE_LO_BIT]}),
    .o_hit(trig_hit)
  );

  // ****************************************
  // sequencing
  // ****************************************
  assign bit_dec = (state_q == adcc_pkg::ADCC_CONV) && (cnt_q == BIT_LAST);
  assign last_bit = bit_dec && (bit_q == 4'h0);
  // (RL12) (RL13) a mode or channel write in the completion cycle wins
  assign done_evt = last_bit && !restart;
  assign start_sample = (state_d == adcc_pkg::ADCC_SAMPLE) &&
                        ((state_q != adcc_pkg::ADCC_SAMPLE) || restart);

  always_comb begin
    state_d = state_q;
    if (wr_mode) begin
      // (RL16) mode write steers start
      if (!i_wdata[`ADCC_MODE_ENABLE_BIT]) begin
        state_d = adcc_pkg::ADCC_IDLE;
      end else if (i_wdata[`ADCC_MODE_SOURCE_BIT]) begin
        state_d = adcc_pkg::ADCC_WAIT;
      end else begin
        state_d = adcc_pkg::ADCC_SAMPLE;
      end
    end else if (wr_chsel && enabled) begin
      // (RL19) channel rewrite restarts
      if (hw_start) begin
        state_d = adcc_pkg::ADCC_WAIT;
      end else begin
        state_d = adcc_pkg::ADCC_SAMPLE;
      end
    end else begin
      case (state_q)
        adcc_pkg::ADCC_IDLE: begin
          state_d = adcc_pkg::ADCC_IDLE;
        end
        adcc_pkg::ADCC_WAIT: begin
          // (RL3) trigger edge starts
          if (trig_hit) begin
            state_d = adcc_pkg::ADCC_SAMPLE;
          end
        end
        adcc_pkg::ADCC_SAMPLE: begin
          // (RL14) short sampling phase
          if (cnt_q == SAMP_LAST) begin
            state_d = adcc_pkg::ADCC_CONV;
          end
        end
        adcc_pkg::ADCC_CONV: begin
          if (last_bit) begin
            // (RL4) hardware mode stops; (RL5) software repeats
            state_d = hw_start ? adcc_pkg::ADCC_WAIT : adcc_pkg::ADCC_SAMPLE;
          end
        end
        default: begin
          state_d = adcc_pkg::ADCC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state_q <= adcc_pkg::ADCC_IDLE;
      sample_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sample_q <= (state_d == adcc_pkg::ADCC_SAMPLE);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      cnt_q <= 3'h0;
    end else if (restart || (state_d != state_q) || bit_dec) begin
      cnt_q <= 3'h0;
    end else if (state_q[3] || state_q[2]) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // ****************************************
  // successive approximation
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      bit_q <= 4'h0;
    end else if (state_q == adcc_pkg::ADCC_SAMPLE && state_d == adcc_pkg::ADCC_CONV) begin
      bit_q <= 4'h9;
    end else if (bit_dec && bit_q != 4'h0) begin
      bit_q <= bit_q - 4'h1;
    end
  end

  // (RL1) ten approximation bits
  genvar gk;
  generate
    for (gk = 0; gk < 10; gk++) begin : g_sar
      always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
          successive_approx_reg_q[gk] <= 1'b0;
        end else if (state_q == adcc_pkg::ADCC_SAMPLE && state_d == adcc_pkg::ADCC_CONV) begin
          // (RL6) msb trial first
          successive_approx_reg_q[gk] <= 1'(`ADCC_MSB_TRIAL >> gk);
        end else if (bit_dec && bit_q == 4'(gk)) begin
          // (RL6) comparator decides bit
          successive_approx_reg_q[gk] <= i_cmp_hi;
        end else if (bit_dec && bit_q == 4'(gk + 1)) begin
          successive_approx_reg_q[gk] <= 1'b1;
        end
      end
    end
  endgenerate

  // ****************************************
  // channel and result
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      chan_q <= `ADCC_CHSEL_RST;
    end else if (start_sample) begin
      // (RL2) channel latched at start
      chan_q <= chsel_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      conversion_result_reg_q <= `ADCC_RESULT_RST;
    end else if (done_evt) begin
      // (RL7) copy into result; (RL18) left aligned
      conversion_result_reg_q <= {successive_approx_reg_q[9:1], i_cmp_hi,
                                  6'h00};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      conv_end_flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_q <= done_evt;
      // (RL9) old channel flag may land before rewrite
      // (RL20) flag with result load; (RL8) set wins, chsel never clears
      if (done_evt) begin
        conv_end_flag_q <= 1'b1;
      end else if (wr_status && i_wdata[`ADCC_STATUS_FLAG_BIT]) begin
        conv_end_flag_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      converter_mode_reg_q <= 7'(`ADCC_MODE_RST >> 1);
    end else if (wr_mode) begin
      converter_mode_reg_q <= i_wdata[7:1];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      channel_select_reg_q <= `ADCC_CHSEL_RST;
    end else if (wr_chsel) begin
      channel_select_reg_q <= i_wdata[2:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      rdata_q <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        `ADCC_ADDR_MODE: rdata_q <= {8'h00, converter_mode_reg_q, 1'b0};
        `ADCC_ADDR_CHSEL: rdata_q <= {13'h0000, channel_select_reg_q};
        `ADCC_ADDR_RESULT: rdata_q <= conversion_result_reg_q;
        `ADCC_ADDR_STATUS: rdata_q <= {13'h0000, state_q[1],
                                       state_q[3] || state_q[2], conv_end_flag_q};
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign o_rdata = rdata_q;
  assign o_chan_sel = chan_q;
  assign o_sample_en = sample_q;
  assign o_tap_code = successive_approx_reg_q;
  assign o_conv_end_irq = irq_q;

  // ****************************************
  // checks
  // ****************************************
  sequence s_sample_run;
    sample_q [*4] ##1 (state_q == adcc_pkg::ADCC_CONV);
  endsequence

  sequence s_sample_cut;
    ##[0:3] restart;
  endsequence

  sequence s_first_trial;
    successive_approx_reg_q == 10'h200 && bit_q == 4'h9;
  endsequence

  // (RL18) low bits zero
  AST_RESULT_PAD: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    conversion_result_reg_q[5:0] == 6'h00)
    else $error("result low bits not zero");

  // (RL20) flag and result together
  AST_FLAG_WITH_RESULT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    done_evt |=> conv_end_flag_q && irq_q &&
    conversion_result_reg_q == {$past(successive_approx_reg_q[9:1]), $past(i_cmp_hi),
                                6'h00})
    else $error("flag or result missing at end of conversion");

  // (RL4) hardware mode stops
  AST_HW_STOPS: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    done_evt && hw_start |=> state_q == adcc_pkg::ADCC_WAIT ##1
    (state_q == adcc_pkg::ADCC_WAIT || $past(trig_hit) || $past(restart)))
    else $error("hardware mode did not stop");

  // (RL5) software mode repeats
  AST_SW_REPEATS: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    done_evt && !hw_start |=> sample_q && state_q == adcc_pkg::ADCC_SAMPLE)
    else $error("software mode did not repeat");

  // (RL8) channel write keeps flag
  AST_CHSEL_KEEPS_FLAG: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    wr_chsel && conv_end_flag_q |=> conv_end_flag_q)
    else $error("channel write cleared flag");

  // (RL19) software channel rewrite restarts
  AST_SW_CHSEL_RESTART: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    wr_chsel && enabled && !hw_start |=> sample_q && cnt_q == 3'h0 &&
    chan_q == $past(i_wdata[2:0]))
    else $error("channel rewrite did not restart");

  // (RL14) sampling length
  AST_SAMPLE_LEN: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    $rose(sample_q) |-> s_sample_run or s_sample_cut)
    else $error("sampling phase length wrong");

  // (RL6) msb trial first
  AST_MSB_FIRST: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    $rose(state_q == adcc_pkg::ADCC_CONV) |-> s_first_trial)
    else $error("conversion did not start at msb");

  // (RL3) trigger edge starts
  AST_TRIG_START: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    state_q == adcc_pkg::ADCC_WAIT && trig_hit && !restart |=> sample_q)
    else $error("trigger edge did not start conversion");

  // (RL2) channel steady in conversion
  AST_CHAN_STEADY: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    state_q == adcc_pkg::ADCC_CONV && $past(state_q) == adcc_pkg::ADCC_CONV |->
    $stable(chan_q))
    else $error("channel changed during conversion");
endmodule
`default_nettype wire

// ==== dv/adcc_analog_model.sv ====
`default_nettype none
// ****************************************
// analog side: input levels and comparator
// ****************************************
module adcc_analog_model (
  input wire logic [79:0] i_levels,
  input wire logic [2:0] i_chan_sel,
  input wire logic [9:0] i_tap_code,
  output logic o_cmp_hi
);
  timeunit 1ns;
  timeprecision 100ps;
  assign o_cmp_hi = (i_levels[i_chan_sel * 10 +: 10] >= i_tap_code);
endmodule
`default_nettype wire

// ==== dv/tb_adcc_top.sv ====
`default_nettype none
module tb_adcc_top;
  timeunit 1ns;
  timeprecision 100ps;
  // channel 7 down to channel 0
  localparam logic [79:0] LEVELS = {10'h3ff, 10'h2aa, 10'h155, 10'h001,
                                    10'h200, 10'h1ff, 10'h0f0, 10'h000};
  logic i_ref_clk, i_resetn, i_wr, i_rd, trig, cmp_hi, se, irq, se1, se5;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, o_rdata, rv;
  logic [2:0] chan;
  logic [9:0] tap, tp5;
  int err_count = 0;
  int cmp_count = 0;
  int irq_cnt = 0;
  int k, base;

  adcc_top uut (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_external_trigger_in(trig),
    .i_cmp_hi(cmp_hi), .o_chan_sel(chan), .o_sample_en(se), .o_tap_code(tap),
    .o_conv_end_irq(irq)
  );
  adcc_analog_model model (
    .i_levels(LEVELS), .i_chan_sel(chan), .i_tap_code(tap), .o_cmp_hi(cmp_hi)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] res_of(input int ch);
    return {LEVELS[ch * 10 +: 10], 6'h00};
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [3:0] a, input logic [15:0] e);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    rv = o_rdata;
    check(n, rv, e);
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    while (n < 200) begin
      n++;
      @(posedge i_ref_clk);
      #1;
      if (n == 1) se1 = se;
      if (n == 5) begin
        se5 = se;
        tp5 = tap;
      end
      if (irq === 1'b1) break;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // clock, pulse counter, watchdog
  // ****************************************
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    err_count++;
    report_and_stop;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    i_resetn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 16'h0000;
    trig = 1'b0;
    repeat (20) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    check("tap reset", {6'h00, tap}, 16'h0000);
    for (int a = 0; a < 4; a++) rchk("reset value", 4'(a), 16'h0000);
    rchk("unmapped", 4'h9, 16'h0000);
    wr(4'h0, 16'h003f);
    rchk("mode", 4'h0, 16'h003e);
    wr(4'h1, 16'hffff);
    rchk("chsel", 4'h1, 16'h0007);
    wr(4'h2, 16'hffff);
    rchk("result ro", 4'h2, 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0003);
    // shared digital port never touched
    // software start
    wr(4'h0, 16'h0080);
    wait_irq(k);
    check("latency", 16'(k), 16'd44);
    check("sampling on", {15'h0, se1}, 16'h0001);
    check("sampling off", {15'h0, se5}, 16'h0000);
    check("msb trial", {6'h00, tp5}, 16'h0200);
    check("chan", {13'h0, chan}, 16'h0003);
    wait_irq(k);
    check("repeat", 16'(k), 16'd44);
    rchk("result", 4'h2, res_of(3));
    rchk("status", 4'h3, 16'h0003);
    repeat (10) @(posedge i_ref_clk);
    wr(4'h1, 16'h0005);
    rchk("flag kept", 4'h3, 16'h0003);
    wait_irq(k);
    check("restart", 16'(k), 16'd42);
    check("chan new", {13'h0, chan}, 16'h0005);
    rchk("result new", 4'h2, res_of(5));
    wr(4'h0, 16'h0000);
    base = irq_cnt;
    repeat (100) @(posedge i_ref_clk);
    check("stopped", 16'(irq_cnt - base), 16'h0000);
    rchk("status stopped", 4'h3, 16'h0001);
    wr(4'h1, 16'h0006);
    // hardware start, every edge setting
    for (int s = 0; s < 4; s++) begin
      wr(4'h0, 16'h0000);
      wr(4'h3, 16'h0001);
      wr(4'h0, 16'h00c0 | 16'(s << 1));
      rchk("waiting", 4'h3, 16'h0004);
      base = irq_cnt;
      @(posedge i_ref_clk);
      trig <= 1'b1;
      repeat (60) @(posedge i_ref_clk);
      check("rise", 16'(irq_cnt - base), 16'(s >> 1));
      base = irq_cnt;
      trig <= 1'b0;
      repeat (60) @(posedge i_ref_clk);
      check("fall", 16'(irq_cnt - base), 16'(s & 1));
      if (s != 0) rchk("hw result", 4'h2, res_of(6));
    end
    // hardware mode channel rewrite aborts back to waiting
    @(posedge i_ref_clk);
    base = irq_cnt;
    trig <= 1'b1;
    repeat (20) @(posedge i_ref_clk);
    wr(4'h1, 16'h0002);
    repeat (60) @(posedge i_ref_clk);
    check("hw abort", 16'(irq_cnt - base), 16'h0000);
    rchk("hw abort wait", 4'h3, 16'h0005);
    report_and_stop;
  end
endmodule
`default_nettype wire
